/* File: dz_ctrl_end.sv */
// Controller end: link clock, command legality timers, read capture FIFO
`timescale 1ns/1ps
`include "dz_regs.svh"
module dz_fifo
   import dz_pkg::*;
#(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   output logic [$clog2(D+1)-1:0] level
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } dz_fifo_st_type;

   dz_fifo_st_type s;
   dz_fifo_st_type n;

   // Push and pop with wrap at depth
   always_comb begin
      logic push;
      logic pop;
      push = in_valid && (s.cnt != (AW+1)'(D));
      pop = out_ready && (s.cnt != '0);
      n = s;
      if (push) begin
         n.mem[s.wp] = in_data;
         n.wp = (s.wp == AW'(D-1)) ? '0 : AW'(s.wp + 1'b1);
      end
      if (pop) begin
         n.rp = (s.rp == AW'(D-1)) ? '0 : AW'(s.rp + 1'b1);
      end
      n.cnt = (AW+1)'(s.cnt + push - pop);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign in_ready = (s.cnt != (AW+1)'(D));
   assign out_valid = (s.cnt != '0);
   assign out_data = s.mem[s.rp];
   assign level = s.cnt;
endmodule

module dz_ctrl_end
   import dz_pkg::*;
#(
   parameter int AL = 0,
   parameter int CL = 5,
   parameter int CWL = 5,
   parameter int CK_DIV = 4,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   dz_link_if.host lk,
   input wire logic req_valid,
   input wire dz_cmd_type req_cmd,
   input wire logic [2:0] req_bank,
   input wire logic [13:0] req_addr,
   input wire logic odt_req,
   output logic req_done,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [7:0] rd_data,
   output logic zq_busy,
   output logic [7:0] bank_open
);
   localparam int RL = AL + CL;
   localparam int WL = AL + CWL;
   localparam int LW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [7:0] div;
      logic ck;
      logic cke;
      logic odt;
      dz_cmd_type cmd;
      logic [2:0] ba;
      logic [13:0] ad;
      logic done;
      logic dqs_m;
      logic dqs_s;
      logic dqs_d;
      logic [7:0] dq_m;
      logic [7:0] dq_s;
      logic [7:0] open;
      logic [7:0][5:0] rc;
      logic [7:0][5:0] rcd;
      logic [7:0][5:0] ras;
      logic [7:0][5:0] rtp;
      logic [7:0][5:0] rp;
      logic [5:0] rrd;
      logic [3:0][5:0] faw;
      logic [5:0] ccd;
      logic [5:0] r2w;
      logic [5:0] mrd;
      logic [9:0] zq;
      logic zq_first;
      logic zq_busy;
      logic [1:0] bl_mode;
      logic [4:0] pend;
   } dz_host_type;

   dz_host_type s;
   dz_host_type n;
   logic push;
   logic [LW-1:0] level;

   // Captured beats land here; the user side drains at its own pace
   dz_fifo #(.W(8), .D(DEPTH)) u_fifo (
      .clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(push),
      .in_ready(),
      .in_data(s.dq_s),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data),
      .level(level)
   );

   // Each strobe transition carries one beat
   assign push = (s.dqs_s != s.dqs_d);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic tog;
      logic rise;
      logic fall;
      logic ok;
      logic idle;
      logic faw_ok;
      logic bc4;
      int slot;
      int room;
      int a;
      n = s;
      tog = (s.div == 8'(CK_DIV - 1));
      rise = tog && !s.ck;
      fall = tog && s.ck;
      ok = 1'b0;
      idle = (s.open == 8'h00) && (s.rp == '0) && (s.mrd == 6'h00);
      faw_ok = 1'b0;
      slot = 0;
      bc4 = dz_bc4(s.bl_mode, req_addr[`DZ_A_BC]);
      room = DEPTH - int'(s.pend) - int'(level);
      a = int'(req_bank);
      n.done = 1'b0;
      n.cke = 1'b1;
      n.odt = odt_req && (s.zq == 10'h000);
      // Link clock divider
      n.div = tog ? 8'h00 : 8'(s.div + 8'h01);
      if (tog) begin
         n.ck = ~s.ck;
      end
      // Strobe and data capture through two flops
      n.dqs_m = lk.dqs;
      n.dqs_s = s.dqs_m;
      n.dqs_d = s.dqs_s;
      n.dq_m = lk.dq;
      n.dq_s = s.dq_m;
      for (int i = 3; i >= 0; i--) begin
         if (s.faw[i] == 6'h00) begin
            faw_ok = 1'b1;
            slot = i;
         end
      end
      // Timers count link cycles at each rising edge
      if (rise) begin
         for (int i = 0; i < 8; i++) begin
            n.rc[i] = dz_dec(s.rc[i]);
            n.rcd[i] = dz_dec(s.rcd[i]);
            n.ras[i] = dz_dec(s.ras[i]);
            n.rtp[i] = dz_dec(s.rtp[i]);
            n.rp[i] = dz_dec(s.rp[i]);
         end
         for (int i = 0; i < 4; i++) begin
            n.faw[i] = dz_dec(s.faw[i]);
         end
         n.rrd = dz_dec(s.rrd);
         n.ccd = dz_dec(s.ccd);
         n.r2w = dz_dec(s.r2w);
         n.mrd = dz_dec(s.mrd);
         n.zq = (s.zq == 10'h000) ? 10'h000 : 10'(s.zq - 10'h001);
      end
      // Legality per command, checked with per-bank and shared timers
      case (req_cmd)
         DZ_ACT: ok = !s.open[a] && s.rc[a] == 6'h00 && s.rp[a] == 6'h00
                      && s.rrd == 6'h00 && faw_ok;
         DZ_RD: ok = s.open[a] && s.rcd[a] == 6'h00
                     && s.ccd == 6'h00 && room >= 8;
         DZ_WR: ok = s.open[a] && s.rcd[a] == 6'h00 && s.ccd == 6'h00
                     && s.r2w == 6'h00;
         DZ_PRE: ok = s.rtp[a] == 6'h00 && s.ras[a] == 6'h00;
         DZ_ZQL, DZ_ZQS: ok = idle;
         DZ_MRS: ok = idle;
         default: ok = 1'b1;
      endcase
      // Nothing but calibrate while calibrating
      if (s.zq != 10'h000 && req_cmd != DZ_ZQL && req_cmd != DZ_ZQS) begin
         ok = 1'b0;
      end
      if (s.mrd != 6'h00) begin
         ok = 1'b0;
      end
      // Commands change on the falling edge, taken on the rising edge
      if (fall) begin
         n.cmd = DZ_NOP;
         if (req_valid && ok) begin
            n.cmd = req_cmd;
            n.ba = req_bank;
            n.ad = req_addr;
            n.done = 1'b1;
            case (req_cmd)
               DZ_ACT: begin
                  n.open[a] = 1'b1;
                  n.rc[a] = 6'(`DZ_N_RC);
                  n.rcd[a] = (`DZ_N_RCD > AL) ? 6'(`DZ_N_RCD - AL) : 6'h00;
                  n.ras[a] = 6'(`DZ_N_RAS);
                  n.rrd = 6'(`DZ_N_RRD);
                  n.faw[slot] = 6'(`DZ_N_FAW);
               end
               DZ_RD: begin
                  n.ccd = 6'(`DZ_N_CCD);
                  n.rtp[a] = 6'(AL + `DZ_N_RTP);
                  n.r2w = 6'(RL + `DZ_N_CCD - WL + 2);
                  n.pend = 5'(s.pend + (bc4 ? 5'h04 : 5'h08));
                  if (req_addr[`DZ_A_AP]) begin
                     n.open[a] = 1'b0;
                     n.rp[a] = 6'(`DZ_MAX(AL + `DZ_N_RTPRP,
                                          int'(s.ras[a]) + `DZ_N_RP));
                  end
               end
               DZ_WR: begin
                  n.ccd = 6'(`DZ_N_CCD);
               end
               DZ_PRE: begin
                  n.open[a] = 1'b0;
                  n.rp[a] = 6'(`DZ_N_RP);
               end
               DZ_ZQL: begin
                  n.zq = s.zq_first ? 10'(`DZ_N_ZQOPER) : 10'(`DZ_N_ZQINIT);
                  n.zq_first = 1'b1;
               end
               DZ_ZQS: begin
                  n.zq = 10'(`DZ_N_ZQCS);
               end
               DZ_MRS: begin
                  n.mrd = 6'(`DZ_N_MOD);
                  if (req_bank == `DZ_MR0) begin
                     n.bl_mode = req_addr[1:0];
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // Beats still owed by the DRAM
      if (push) begin
         n.pend = 5'(n.pend - 5'h01);
      end
      n.zq_busy = (n.zq != 10'h000);
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // Outputs from flops
   assign lk.ck = s.ck;
   assign lk.cke = s.cke;
   assign lk.odt = s.odt;
   assign lk.cmd = s.cmd;
   assign lk.ba = s.ba;
   assign lk.addr = s.ad;
   assign req_done = s.done;
   assign zq_busy = s.zq_busy;
   assign bank_open = s.open;
endmodule

/* File: dz_dram_end.sv */
// DRAM end: command decode, read burst output, auto precharge, calibration
`timescale 1ns/1ps
`include "dz_regs.svh"
module dz_dram_end
   import dz_pkg::*;
#(
   parameter int AL = 0,
   parameter int CL = 5
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   dz_link_if.dev lk,
   output logic [7:0] bank_open,
   output logic [1:0] burst_mode,
   output logic zq_path_en
);
   localparam int RL = AL + CL;

   typedef struct packed {
      logic ck_m;
      logic ck_s;
      logic ck_d;
      logic [2:0] cmd_m;
      logic [2:0] cmd_s;
      logic [2:0] ba_m;
      logic [2:0] ba_s;
      logic [13:0] ad_m;
      logic [13:0] ad_s;
      logic [`DZ_PIPE-1:0][9:0] pipe;
      dz_bst_type bst;
      logic [2:0] beats;
      logic [2:0] idx;
      logic [7:0] col;
      logic [7:0] dq;
      logic dq_oe;
      logic dqs;
      logic dqs_oe;
      logic [1:0] bl_mode;
      logic [7:0] open;
      logic [7:0] ap;
      logic [7:0][5:0] ras;
      logic [7:0][5:0] apw;
      logic zq_first;
      logic [9:0] zq;
      logic zq_path;
   } dz_dev_type;

   dz_dev_type s;
   dz_dev_type n;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic rise;
      logic edg;
      logic [2:0] b;
      rise = s.ck_s & ~s.ck_d;
      edg = s.ck_s ^ s.ck_d;
      b = s.ba_s;
      n = s;
      // Pins pass two flops before use
      n.ck_m = lk.ck;
      n.ck_s = s.ck_m;
      n.ck_d = s.ck_s;
      n.cmd_m = lk.cmd;
      n.cmd_s = s.cmd_m;
      n.ba_m = lk.ba;
      n.ba_s = s.ba_m;
      n.ad_m = lk.addr;
      n.ad_s = s.ad_m;
      // One data beat per clock crossing
      if (edg) begin
         case (s.bst)
            DZ_BURST: begin
               if (s.beats != 3'h0) begin
                  n.dq = 8'(s.col + {5'h00, s.idx});
                  n.dqs = ~s.dqs;
                  n.beats = 3'(s.beats - 3'h1);
                  n.idx = 3'(s.idx + 3'h1);
               end else begin
                  n.bst = DZ_POST;
                  n.dq_oe = 1'b0;
               end
            end
            DZ_POST: begin
               n.bst = DZ_IDLE;
               n.dqs_oe = 1'b0;
            end
            default: begin
            end
         endcase
      end
      if (rise) begin
         // Read latency pipeline: valid, chop, column
         n.pipe = {s.pipe[`DZ_PIPE-2:0],
                   {(s.cmd_s == DZ_RD), dz_bc4(s.bl_mode, s.ad_s[`DZ_A_BC]),
                    s.ad_s[7:0]}};
         if (n.pipe[RL-1][9] && s.bst != DZ_BURST) begin
            n.bst = DZ_PREAM;
            n.dqs_oe = 1'b1;
            n.dqs = 1'b0;
            n.dq_oe = 1'b0;
         end
         if (n.pipe[RL][9]) begin
            n.bst = DZ_BURST;
            n.beats = n.pipe[RL][8] ? 3'h3 : 3'h7;
            n.idx = 3'h1;
            n.col = n.pipe[RL][7:0];
            n.dq = n.pipe[RL][7:0];
            n.dq_oe = 1'b1;
            n.dqs = 1'b1;
            n.dqs_oe = 1'b1;
         end
         // Row-active age and auto precharge lockout per bank
         for (int i = 0; i < 8; i++) begin
            if (s.ras[i] != 6'h3F) begin
               n.ras[i] = 6'(s.ras[i] + 6'h01);
            end
            if (s.ap[i]) begin
               if (s.apw[i] != 6'h00) begin
                  n.apw[i] = dz_dec(s.apw[i]);
               end else if (s.ras[i] >= 6'(`DZ_N_RAS)) begin
                  n.open[i] = 1'b0;
                  n.ap[i] = 1'b0;
               end
            end
         end
         if (s.zq != 10'h000) begin
            n.zq = 10'(s.zq - 10'h001);
         end
         case (s.cmd_s)
            DZ_ACT: begin
               n.open[b] = 1'b1;
               n.ras[b] = 6'h00;
            end
            DZ_PRE: begin
               n.open[b] = 1'b0;
               n.ap[b] = 1'b0;
            end
            DZ_RD: begin
               if (s.ad_s[`DZ_A_AP]) begin
                  n.ap[b] = 1'b1;
                  n.apw[b] = 6'(AL + `DZ_N_RTP - 1);
               end
            end
            DZ_ZQL: begin
               n.zq = s.zq_first ? 10'(`DZ_N_ZQOPER) : 10'(`DZ_N_ZQINIT);
               n.zq_first = 1'b1;
            end
            DZ_ZQS: begin
               n.zq = 10'(`DZ_N_ZQCS);
            end
            DZ_MRS: begin
               if (b == `DZ_MR0) begin
                  n.bl_mode = s.ad_s[1:0];
               end
            end
            default: begin
            end
         endcase
      end
      // Resistor current only while calibrating
      n.zq_path = (n.zq != 10'h000);
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // Outputs from flops
   assign lk.dq_o = s.dq;
   assign lk.dq_oe = s.dq_oe;
   assign lk.dqs_o = s.dqs;
   assign lk.dqs_n_o = ~s.dqs;
   assign lk.dqs_oe = s.dqs_oe;
   assign bank_open = s.open;
   assign burst_mode = s.bl_mode;
   assign zq_path_en = s.zq_path;
endmodule

/* File: dz_link_if.sv */
// Link pins between controller end and DRAM end
`timescale 1ns/1ps
interface dz_link_if;
   import dz_pkg::*;
   logic ck;
   logic cke;
   logic odt;
   dz_cmd_type cmd;
   logic [2:0] ba;
   logic [13:0] addr;
   logic [7:0] dq_o;
   logic dq_oe;
   logic dqs_o;
   logic dqs_n_o;
   logic dqs_oe;
   logic [7:0] dq;
   logic dqs;
   logic dqs_n;

   // Wire levels; a floating strobe pair rests low/high
   assign dq = dq_oe ? dq_o : 8'h00;
   assign dqs = dqs_oe ? dqs_o : 1'b0;
   assign dqs_n = dqs_oe ? dqs_n_o : 1'b1;

   modport host (output ck, cke, odt, cmd, ba, addr, input dq, dqs, dqs_n);
   modport dev (input ck, cke, odt, cmd, ba, addr,
                output dq_o, dq_oe, dqs_o, dqs_n_o, dqs_oe);
endinterface

/* File: dz_pkg.sv */
// Types and shared decode for the DDR3 link ends
package dz_pkg;
   `include "dz_regs.svh"

   typedef enum logic [2:0] {
      DZ_NOP = 3'h0, DZ_ACT = 3'h1, DZ_RD = 3'h2, DZ_WR = 3'h3,
      DZ_PRE = 3'h4, DZ_ZQL = 3'h5, DZ_ZQS = 3'h6, DZ_MRS = 3'h7
   } dz_cmd_type;

   typedef enum logic [1:0] {
      DZ_IDLE = 2'h0, DZ_PREAM = 2'h1, DZ_BURST = 2'h3, DZ_POST = 2'h2
   } dz_bst_type;

   // Four-beat chop decision from mode field and bit 12
   function automatic logic dz_bc4(input logic [1:0] mode, input logic a12);
      return (mode == `DZ_BL_FIX4) || ((mode == `DZ_BL_OTF) && !a12);
   endfunction

   // Saturating count down
   function automatic logic [5:0] dz_dec(input logic [5:0] v);
      return (v == 6'h00) ? 6'h00 : 6'(v - 6'h01);
   endfunction
endpackage

/* File: dz_regs.svh */
// Constants for the DDR3 calibrate/activate/read link: timing counts and fields
`ifndef DZ_REGS_SVH
`define DZ_REGS_SVH
// Contract
// - Calibrate only with all banks precharged
// - During calibration, only further calibrate commands
// - Device cuts resistor current after calibration
// - Calibrate may overlap DLL lock; explicit long
// - Shared resistor: rank calibrations never overlap
// - Clock enable high, termination off, bus floating
// - Open a row before reading that bank
// - Read waits row-to-column, less additive latency
// - Times become cycles, rounded up
// - Reads spaced by column-to-column delay
// - Same bank: precharge first, row cycle spacing
// - Row-to-row spacing, four activates per window
// - First data read latency after read
// - Strobe preamble and postamble, then float
// - Column-spaced reads stream; chop leaves gap
// - Read bursts always run to completion
// - Read-to-write spacing RL+CCD-WL+2
// - Precharge after read: four clocks, read-to-precharge
// - Precharge period timed from last precharge
// - Address bit 10 starts auto precharge
// - Auto precharge waits four clocks, row-active lockout
// - Mode field and bit 12 choose burst length
// - Mode writes only idle, then wait delays
// ------------------------------------------------------------
// Link timing
// ------------------------------------------------------------
`define DZ_TCK_PS 160000
`define DZ_CEIL(ps) (((ps) + `DZ_TCK_PS - 1) / `DZ_TCK_PS)
`define DZ_MAX(a, b) (((a) > (b)) ? (a) : (b))
`define DZ_T_RCD_PS 13750
`define DZ_T_RP_PS 13750
`define DZ_T_RAS_PS 35000
`define DZ_T_RC_PS 48750
`define DZ_T_RRD_PS 6000
`define DZ_T_FAW_PS 30000
`define DZ_T_RTP_PS 7500
`define DZ_N_FLOOR 4
`define DZ_N_CCD 4
`define DZ_N_RCD `DZ_CEIL(`DZ_T_RCD_PS)
`define DZ_N_RP `DZ_CEIL(`DZ_T_RP_PS)
`define DZ_N_RAS `DZ_CEIL(`DZ_T_RAS_PS)
`define DZ_N_RC `DZ_CEIL(`DZ_T_RC_PS)
`define DZ_N_RRD `DZ_MAX(`DZ_N_FLOOR, `DZ_CEIL(`DZ_T_RRD_PS))
`define DZ_N_FAW `DZ_CEIL(`DZ_T_FAW_PS)
`define DZ_N_RTP `DZ_MAX(`DZ_N_FLOOR, `DZ_CEIL(`DZ_T_RTP_PS))
`define DZ_N_RTPRP `DZ_CEIL(`DZ_T_RTP_PS + `DZ_T_RP_PS)
`define DZ_N_MOD 12
`define DZ_N_ZQINIT 512
`define DZ_N_ZQOPER 256
`define DZ_N_ZQCS 64
// ------------------------------------------------------------
// Fields
// ------------------------------------------------------------
`define DZ_BL_FIX8 2'h0
`define DZ_BL_OTF 2'h1
`define DZ_BL_FIX4 2'h2
`define DZ_A_AP 10
`define DZ_A_BC 12
`define DZ_MR0 3'h0
`define DZ_PIPE 32
`endif

/* File: dz_sva.sv */
// Checker for the command and read strobe link between both ends
`timescale 1ns/1ps
module dz_sva
   import dz_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cke,
   input wire logic odt,
   input wire dz_cmd_type cmd,
   input wire logic dq_oe,
   input wire logic dqs_o,
   input wire logic dqs_n_o,
   input wire logic dqs_oe
);
   // ----------------------------------------
   // Helper counters
   // ----------------------------------------
   logic [11:0] zq_left;
   logic [7:0] act_gap;
   logic [7:0] rd_gap;
   logic [7:0] run;
   dz_cmd_type prev_cmd;
   logic zq_start;
   logic act_start;
   logic rd_start;

   // Start of a command on the pins
   assign zq_start = (cmd == DZ_ZQS || cmd == DZ_ZQL) && prev_cmd != cmd;
   assign act_start = cmd == DZ_ACT && prev_cmd != DZ_ACT;
   assign rd_start = cmd == DZ_RD && prev_cmd != DZ_RD;

   // Quiet window, spacing and data run lengths in clock cycles
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         zq_left <= 12'h000;
         act_gap <= 8'hFF;
         rd_gap <= 8'hFF;
         run <= 8'h00;
         prev_cmd <= DZ_NOP;
      end else begin
         prev_cmd <= cmd;
         zq_left <= zq_start ? 12'h200 : ((zq_left != 12'h000) ? zq_left - 12'h001 : zq_left);
         act_gap <= act_start ? 8'h00 : ((act_gap != 8'hFF) ? act_gap + 8'h01 : act_gap);
         rd_gap <= rd_start ? 8'h00 : ((rd_gap != 8'hFF) ? rd_gap + 8'h01 : rd_gap);
         run <= dq_oe ? run + 8'h01 : 8'h00;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_cke_held: assert property ($past(rst_n) |-> cke)
      else $error("clock enable dropped");
   a_zq_quiet: assert property (zq_left != 12'h000 |-> cmd inside {DZ_NOP, DZ_ZQS, DZ_ZQL})
      else $error("command during calibration");
   a_zq_odt_off: assert property (zq_left > 12'h010 && zq_left < 12'h1F0 |-> !odt)
      else $error("termination on during calibration");
   a_zq_bus_float: assert property (zq_left != 12'h000 |-> !dq_oe && !dqs_oe)
      else $error("data bus driven during calibration");
   a_act_spacing: assert property (act_start |-> act_gap >= 8'd31)
      else $error("activates too close");
   a_read_spacing: assert property (rd_start |-> rd_gap >= 8'd31)
      else $error("reads too close");
   a_read_latency: assert property ($rose(cmd == DZ_RD) |-> ##[44:52] dq_oe)
      else $error("read data late or missing");
   a_preamble_low: assert property ($rose(dqs_oe) |-> !dqs_o && dqs_n_o && !dq_oe)
      else $error("no read preamble");
   a_strobe_pair: assert property (dqs_oe |-> dqs_o != dqs_n_o)
      else $error("strobe pair not complementary");
   a_burst_whole: assert property ($fell(dq_oe) |-> run[3:0] == 4'h0 && run != 8'h00)
      else $error("read burst truncated");

   // Main scenarios reached
   c_zq: cover property (zq_left == 12'h001);
   c_chop: cover property ($fell(dq_oe) && run == 8'd16);
   c_seamless: cover property ($fell(dq_oe) && run == 8'd64);
   c_act: cover property (act_start && act_gap < 8'd40);
endmodule

/* File: dz_tb.sv */
// Bench for the DDR3 link: controller end facing DRAM end
`timescale 1ns/1ps
`include "dz_regs.svh"
module dz_tb
   import dz_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   dz_cmd_type req_cmd = DZ_NOP;
   logic [2:0] req_bank = 3'h0;
   logic [13:0] req_addr = 14'h0000;
   logic odt_req = 1'b0;
   logic rd_ready = 1'b0;
   logic req_done;
   logic rd_valid;
   logic zq_busy;
   logic zq_path_en;
   logic [7:0] rd_data;
   logic [7:0] c_open;
   logic [7:0] d_open;
   logic [1:0] burst_mode;
   logic [1:0] md [4] = '{`DZ_BL_FIX8, `DZ_BL_OTF, `DZ_BL_OTF, `DZ_BL_FIX4};
   logic a12 [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
   dz_cmd_type zq_op [3] = '{DZ_ZQS, DZ_ZQL, DZ_ZQL};
   int zq_len [3] = '{`DZ_N_ZQCS * 8, `DZ_N_ZQINIT * 8, `DZ_N_ZQOPER * 8};
   int num_errors = 0;
   int checked = 0;
   int cyc = 0;
   int n_done = 0;

   dz_link_if lk ();
   dz_ctrl_end dz_ctrl_end_i (.ref_clk(ref_clk), .rst_n(rst_n), .lk(lk.host),
      .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
      .odt_req(odt_req), .req_done(req_done), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .rd_data(rd_data), .zq_busy(zq_busy), .bank_open(c_open));
   dz_dram_end dz_dram_end_i (.ref_clk(ref_clk), .rst_n(rst_n), .lk(lk.dev),
      .bank_open(d_open), .burst_mode(burst_mode), .zq_path_en(zq_path_en));
   dz_sva dz_sva_i (.ref_clk(ref_clk), .rst_n(rst_n), .cke(lk.cke), .odt(lk.odt),
      .cmd(lk.cmd), .dq_oe(lk.dq_oe), .dqs_o(lk.dqs_o), .dqs_n_o(lk.dqs_n_o),
      .dqs_oe(lk.dqs_oe));

   // 50 MHz clock
   always #10 ref_clk = ~ref_clk;

   // Cycle count, accepted requests, hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (req_done === 1'b1) begin
         n_done <= n_done + 1;
      end
      if (cyc == 30000) begin
         num_errors = num_errors + 1;
         summarize();
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Hold a request until the controller puts it on the pins
   task automatic issue(input dz_cmd_type c, input logic [2:0] b, input logic [13:0] a,
                        output int t);
      int n;
      n = 0;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_cmd <= c;
      req_bank <= b;
      req_addr <= a;
      do begin
         @(posedge ref_clk);
         n = n + 1;
      end while (req_done !== 1'b1 && n < 8000);
      req_valid <= 1'b0;
      t = cyc;
      if (n >= 8000) check("request taken", 16'h0000, 16'h0001);
   endtask

   // Pop read beats, expecting column plus beat index
   task automatic drain(input logic [7:0] col, input int beats);
      int k;
      int n;
      k = 0;
      n = 0;
      rd_ready <= 1'b1;
      while (k < beats && n < 2000) begin
         @(posedge ref_clk);
         n = n + 1;
         if (rd_valid === 1'b1) begin
            check("read beat", {8'h00, rd_data}, {8'h00, 8'(col + k)});
            k = k + 1;
         end
      end
      rd_ready <= 1'b0;
      check("beat count", 16'(k), 16'(beats));
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      int t0;
      int t1;
      int n;
      int m;
      int len;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      check("clock enable", {15'h0, lk.cke}, 16'h1);
      check("idle strobe", {14'h0, lk.dqs, lk.dqs_n}, 16'h1);
      check("open banks", {c_open, d_open}, 16'h0000);
      $display("test reset done");
      // Both calibration kinds with termination requested
      odt_req <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         issue(zq_op[i], 3'h0, 14'h0000, t0);
         repeat (40) @(posedge ref_clk);
         check("calibrating", {13'h0, zq_busy, zq_path_en, lk.odt}, 16'h6);
         n = 40;
         while (zq_busy === 1'b1 && n < 9000) begin
            @(posedge ref_clk);
            n = n + 1;
         end
         check("calibration length", 16'(n >= zq_len[i] - 16 && n <= zq_len[i] + 8), 16'h1);
         repeat (40) @(posedge ref_clk);
         check("resistor path off", {15'h0, zq_path_en}, 16'h0);
      end
      odt_req <= 1'b0;
      $display("test calibration done");
      // Every burst mode, read then early precharge
      for (int i = 0; i < 4; i++) begin
         len = (md[i] == `DZ_BL_FIX4 || (md[i] == `DZ_BL_OTF && !a12[i])) ? 4 : 8;
         issue(DZ_MRS, 3'h0, {12'h000, md[i]}, t0);
         issue(DZ_ACT, 3'h1, 14'h0123, t1);
         check("mode delay", 16'(t1 - t0 >= 96), 16'h1);
         check("burst mode", {14'h0, burst_mode}, {14'h0, md[i]});
         issue(DZ_RD, 3'h1, {1'b0, a12[i], 4'h0, 8'(8'h30 + 16 * i)}, t0);
         check("row open", {c_open, d_open}, 16'h0202);
         issue(DZ_PRE, 3'h1, 14'h0000, t1);
         check("read to precharge", 16'(t1 - t0 >= 32 && t1 - t0 <= 40), 16'h1);
         drain(8'(8'h30 + 16 * i), len);
         repeat (60) @(posedge ref_clk);
         check("no extra beats", {15'h0, rd_valid}, 16'h0);
      end
      $display("test burst modes done");
      // Seamless reads fill the buffer, read to write, refused read
      issue(DZ_MRS, 3'h0, {12'h000, `DZ_BL_OTF}, t0);
      issue(DZ_ACT, 3'h2, 14'h0040, t0);
      issue(DZ_RD, 3'h2, 14'h1010, t0);
      issue(DZ_RD, 3'h2, 14'h1018, t1);
      check("read to read", 16'(t1 - t0 >= 32 && t1 - t0 <= 40), 16'h1);
      issue(DZ_WR, 3'h2, 14'h0000, t0);
      check("read to write", 16'(t0 - t1 >= 48 && t0 - t1 <= 56), 16'h1);
      @(posedge ref_clk);
      m = n_done;
      fork
         issue(DZ_RD, 3'h2, 14'h0440, t0);
         begin
            repeat (300) @(posedge ref_clk);
            check("full buffer refuses", 16'(n_done - m), 16'h0);
            drain(8'h10, 16);
         end
      join
      repeat (20) @(posedge ref_clk);
      check("bank open before auto close", {15'h0, d_open[2]}, 16'h1);
      repeat (60) @(posedge ref_clk);
      check("auto precharge closed", {14'h0, c_open[2], d_open[2]}, 16'h0);
      drain(8'h40, 4);
      $display("test seamless and auto precharge done");
      // Activates to five banks back to back
      for (int b = 3; b < 8; b++) begin
         issue(DZ_ACT, 3'(b), 14'h0100, t1);
         if (b > 3) check("activate spacing", 16'(t1 - t0 >= 32 && t1 - t0 <= 40), 16'h1);
         t0 = t1;
      end
      repeat (20) @(posedge ref_clk);
      check("open banks", {c_open, d_open}, 16'hF8F8);
      $display("test activates done");
      summarize();
   end
endmodule
